// File: dv/dds_host_port.sv
`timescale 1ns/1ps
module dds_host_port (
   input wire logic clk, // master clock, pacing only
   output logic frame_sync_n, // frame, active low
   output logic serial_clock, // bit clock
   output logic serial_data_in // serial data
);
   initial begin
      frame_sync_n = 1'b1;
      serial_clock = 1'b1;
      serial_data_in = 1'b0;
   end
   // nbits below 16 cuts the frame short on purpose
   task automatic send(input logic [15:0] w, input int nbits,
      input logic idle);
      serial_clock <= idle;
      repeat (3) @(posedge clk);
      frame_sync_n <= 1'b0;
      for (int b = 15; b > 15 - nbits; b--) begin
         serial_clock <= 1'b1;
         serial_data_in <= w[b];
         repeat (3) @(posedge clk);
         serial_clock <= 1'b0;
         repeat (3) @(posedge clk);
      end
      frame_sync_n <= 1'b1;
      serial_data_in <= ~serial_data_in;
      serial_clock <= idle;
      repeat (3) @(posedge clk);
   endtask
endmodule // dds_host_port

// File: dv/dds_serial_load_asserts.sv
`timescale 1ns/1ps
module dds_load_checker (
   input wire logic CLK, // master clock
   input wire logic ARST_N, // async reset
   input wire logic CE, // clock enable
   input wire logic PSEL, // apb select
   input wire logic PENABLE, // apb enable
   input wire logic PWRITE, // apb direction
   input wire logic [7:0] PADDR, // apb address
   input wire logic [31:0] PRDATA, // apb read data
   input wire logic PREADY, // apb ready
   input wire logic PSLVERR, // apb error
   input wire logic [11:0] PHASE_ADDR, // sine table address
   input wire logic POWER_DOWN // sleep state
);
   logic bad_addr;
   assign bad_addr = PADDR > 8'h1C || PADDR[1:0] != 2'h0;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   sequence s_rd_setup;
      PSEL && !PENABLE && !PWRITE && CE;
   endsequence
   sequence s_access;
      PSEL && PENABLE;
   endsequence
   a_read_no_wait: assert property (s_rd_setup ##1 s_access |-> PREADY)
      else $error("read not answered in first access cycle");
   a_unmapped_err: assert property (PSEL && PENABLE && bad_addr |-> PSLVERR)
      else $error("unmapped access without error");
   a_mapped_no_err: assert property (PSEL && PENABLE && !bad_addr |-> !PSLVERR)
      else $error("error on a mapped access");
   a_write_ready: assert property (PSEL && PENABLE && PWRITE &&
      PADDR != 8'h18 |-> PREADY == CE)
      else $error("write ready does not follow clock enable");
   a_rdata_hold: assert property (!(PSEL && !PENABLE && CE) |=>
      $stable(PRDATA))
      else $error("read data moved outside a setup capture");
   a_rst_values: assert property ($rose(ARST_N) |->
      PHASE_ADDR == 12'h000 && !POWER_DOWN && PRDATA == 32'h0)
      else $error("outputs not cleared by reset");
   a_sleep_hold: assert property (POWER_DOWN [*4] |-> $stable(PHASE_ADDR))
      else $error("phase address moved while asleep");
   a_ce_hold: assert property (!CE |=> $stable(PHASE_ADDR) &&
      $stable(POWER_DOWN))
      else $error("state moved with clock enable low");
endmodule // dds_load_checker

// File: dv/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
   num_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
   logic CLK = 1'b0, ARST_N = 1'b0, CE = 1'b1;
   logic FREQ_REG_SELECT = 1'b0, PHASE_SELECT_LO = 1'b0;
   logic PHASE_SELECT_HI = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
   logic PWRITE = 1'b0, PREADY, PSLVERR, POWER_DOWN, err;
   logic FRAME_SYNC_N, SERIAL_CLOCK, SERIAL_DATA_IN;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd, a0, a1;
   logic [11:0] PHASE_ADDR;
   logic [15:0] dest [8];
   logic [15:0] defer, data, v;
   logic [2:0] pins;
   int num_errors = 0, comparisons = 0, cycles = 0, seed = 32'h88c9, i;
   always #20 CLK = ~CLK;
   dds_host_port host (.clk(CLK), .frame_sync_n(FRAME_SYNC_N),
      .serial_clock(SERIAL_CLOCK), .serial_data_in(SERIAL_DATA_IN));
   dds_serial_load_control uut (.CLK, .ARST_N, .CE, .FRAME_SYNC_N,
      .SERIAL_CLOCK, .SERIAL_DATA_IN, .FREQ_REG_SELECT, .PHASE_SELECT_LO,
      .PHASE_SELECT_HI, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
      .PREADY, .PSLVERR, .PHASE_ADDR, .POWER_DOWN);
   task test_done;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // keep leaves psel up for a back-to-back setup
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic keep);
      int n;
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      @(posedge CLK);
      while (PREADY !== 1'b1 && n < 50) begin
         @(posedge CLK);
         n++;
      end
      if (n == 50) num_errors++;
      rd = PRDATA;
      err = PSLVERR;
      if (!keep) begin
         PSEL <= 1'b0;
         PENABLE <= 1'b0;
         @(posedge CLK);
      end
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 1'b0);
      `CHK(rd, e)
   endtask
   task acc;
      apb(1'b0, 8'h1C, 32'h0, 1'b1);
      a0 = rd;
      apb(1'b0, 8'h1C, 32'h0, 1'b0);
      a1 = rd;
   endtask
   task model(input logic [15:0] w);
      if (w[15:13] == 3'b000) begin
         if (w[8]) defer[15:8] = w[7:0];
         else defer[7:0] = w[7:0];
         if (w[12]) data = defer;
         if (w[12]) dest[w[11:9]] = data;
      end
   endtask
   task word(input logic [15:0] w);
      host.send(w, 16, 1'($random(seed)));
      model(w);
      repeat (8) @(posedge CLK);
   endtask
   initial begin
      for (i = 0; i < 8; i++) dest[i] = 16'h0000;
      defer = 16'h0000;
      data = 16'h0000;
      repeat (4) @(posedge CLK);
      ARST_N <= 1'b1;
      repeat (4) @(posedge CLK);
      rdc(8'h00, 32'h8);
      rdc(8'h04, 32'h0);
      apb(1'b0, 8'h20, 32'h0, 1'b0);
      `CHK(err, 1'b1)
      apb(1'b1, 8'h05, 32'hFFFF, 1'b0);
      `CHK(err, 1'b1)
      apb(1'b1, 8'h00, 32'hFFFFFFFF, 1'b0);
      rdc(8'h00, 32'h8);
      for (i = 0; i < 8; i++) begin
         v = 16'($random(seed));
         if (i >= 4) v[15:12] = 4'h0;
         word({4'h0, i[2:0], 1'b1, v[15:8]});
         rdc(8'h14, {data, defer});
         word({4'h1, i[2:0], 1'b0, v[7:0]});
      end
      for (i = 0; i < 4; i++) begin
         rdc(8'(4 + 4 * i), {dest[2 * i + 1], dest[2 * i]});
      end
      word(16'h11A5);
      rdc(8'h04, {dest[1], dest[0]});
      word(16'hB000);
      rdc(8'h00, 32'hB);
      word(16'hC800);
      rdc(8'h00, 32'h0);
      pins = 3'($random(seed));
      {PHASE_SELECT_HI, PHASE_SELECT_LO, FREQ_REG_SELECT} <= pins;
      repeat (10) @(posedge CLK);
      apb(1'b0, 8'h00, 32'h0, 1'b0);
      `CHK(rd[6:4], pins)
      {PHASE_SELECT_HI, PHASE_SELECT_LO, FREQ_REG_SELECT} <= 3'b010;
      word(16'h9000);
      word(16'h2C00);
      apb(1'b0, 8'h00, 32'h0, 1'b0);
      `CHK(rd[6:4], 3'b101)
      acc;
      `CHK(a1 - a0, 32'(2 * {dest[3], dest[2]}))
      word(16'hE000);
      `CHK(POWER_DOWN, 1'b1)
      acc;
      `CHK(a1 - a0, 32'h0)
      CE <= 1'b0;
      repeat (3) @(posedge CLK);
      CE <= 1'b1;
      word(16'hD000);
      `CHK(POWER_DOWN, 1'b0)
      `CHK(PHASE_ADDR, dest[6][11:0])
      acc;
      `CHK(a1, 32'h0)
      rdc(8'h04, {dest[1], dest[0]});
      host.send(16'h1177, 9, 1'b0);
      repeat (8) @(posedge CLK);
      rdc(8'h04, {dest[1], dest[0]});
      apb(1'b0, 8'h00, 32'h0, 1'b0);
      `CHK(rd[15:8], 8'h01)
      apb(1'b1, 8'h18, 32'hFFFF125A, 1'b0);
      model(16'h125A);
      repeat (8) @(posedge CLK);
      rdc(8'h04, {dest[1], dest[0]});
      test_done;
   end
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 10000) begin
         num_errors++;
         test_done;
      end
   end
endmodule // tb
bind dds_serial_load_control dds_load_checker chk (.CLK, .ARST_N, .CE,
   .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR,
   .PHASE_ADDR, .POWER_DOWN);

// File: hw/dds_pin_sync.sv
`timescale 1ns/1ps
module dds_pin_sync #(
   parameter int WIDTH = 3,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,               // master clock
   input wire logic arst_n,            // async reset, active low
   input wire logic ce,                // clock enable
   input wire logic [WIDTH-1:0] d,     // asynchronous pins
   output logic [WIDTH-1:0] q          // synchronised copy
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } state_s;

   state_s s;
   state_s next_s;

   // first stage feeds only the second stage
   always_comb begin
      next_s.s1 = d;
      next_s.s2 = s.s1;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= {RST_VAL, RST_VAL};
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign q = s.s2;
endmodule // dds_pin_sync

// File: hw/dds_serial_load_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// (R01) one frame carries exactly one 16-bit word, frame sync low throughout
// (R02) bits taken on serial clock falling edges after frame start, MSB first
// (R03) host raises frame sync after sixteen falling edges
// (R04) serial clock may run freely or idle high or low
// (R05) data word: command nibble, destination address nibble, data byte
// (R06) deferred write fills one defer byte only
// (R07) direct write fills defer byte, copies defer to data, destination next
// (R08) host writes deferred then direct; later direct-only updates allowed
// (R09) host zeroes top four bits for twelve-bit phase registers
// (R10) frequency words held as independent upper and lower halves
// (R11) selection from pins when select_source 0, from bits when 1
// (R12) clear forces select_source and clock_align_enable to zero
// (R13) transfers follow the sixteenth falling edge, destination one clock later
// (R14) clock alignment adds a two-stage pipeline before transfers take effect
// (R15) clock alignment resamples select pins, otherwise bypassed
// (R16) select pin change reaches output after six, or eight aligned, clocks
// (R17) write to selected register reaches output after six or eight clocks; frequency register writes take seven or nine
// (R18) reset bit zeroes accumulator, leaves frequency and phase registers
// (R19) host holds reset, clears, loads registers, then releases reset
// (R20) output resumes six clocks after reset bit is cleared
// (R21) frequency is clock times tuning word over 2^32, phase 2pi/4096 steps
// (R22) host must write control word to enable alignment or bit selection
// (R23) command 10 sets clock_align_enable from bit 13, select_source bit 12
// (R24) command 11 sets sleep bit 13, reset bit 12, clear bit 11
// (R25) sleep stops the phase path; awake runs normally
// (R26) phase offset added to accumulator top bits, twelve-bit table address
// (R27) partial word at frame end is discarded without any transfer
module dds_serial_load_control (
   input wire logic CLK,                   // master clock, 25 MHz
   input wire logic ARST_N,                // async reset, active low
   input wire logic CE,                    // clock enable, freezes state low
   input wire logic FRAME_SYNC_N,          // serial frame, active low
   input wire logic SERIAL_CLOCK,          // serial bit clock
   input wire logic SERIAL_DATA_IN,        // serial data
   input wire logic FREQ_REG_SELECT,       // frequency register select pin
   input wire logic PHASE_SELECT_LO,       // phase select pin, low bit
   input wire logic PHASE_SELECT_HI,       // phase select pin, high bit
   input wire logic PSEL,                  // apb select
   input wire logic PENABLE,               // apb enable
   input wire logic PWRITE,                // apb direction
   input wire logic [7:0] PADDR,           // apb byte address
   input wire logic [31:0] PWDATA,         // apb write data
   output logic [31:0] PRDATA,             // apb read data
   output logic PREADY,                    // apb ready
   output logic PSLVERR,                   // apb error, unmapped address
   output logic [11:0] PHASE_ADDR,         // sine table address
   output logic POWER_DOWN                 // sleep state
);
   typedef struct packed {
      logic sclk_prev;
      logic [4:0] bit_cnt;
      logic [15:0] shift;
      logic [1:0] pipe_v;
      logic [1:0][15:0] pipe_w;
      logic [15:0] defer;
      logic [15:0] data;
      logic dest_pending;
      logic [2:0] dest_idx;
      logic [3:0][15:0] freq_half;
      logic [3:0][11:0] phase;
      logic fsel_bit;
      logic [1:0] psel_bit;
      logic clock_align_enable;
      logic select_source;
      logic sleep;
      logic reset_bit;
      logic [1:0][2:0] pin_pipe;
      logic sel_freq;
      logic [1:0] sel_phase;
      logic [1:0] sel_phase_d;
      logic [31:0] acc;
      logic [11:0] phase_sum;
      logic [11:0] phase_out;
      logic [7:0] drop_cnt;
      logic [31:0] rdata;
      logic rd_ready;
      logic inject_v;
      logic [15:0] inject_w;
   } state_s;

   state_s s;
   state_s next_s;
   logic [2:0] ser_pins;
   logic [2:0] sel_pins;

   function automatic logic [31:0] freq_of(input logic [3:0][15:0] h,
                                           input logic f);
      freq_of = f ? {h[3], h[2]} : {h[1], h[0]};
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a[1:0] == 2'h0) && (a <= dds_serial_load_pkg::OFS_ACCUM);
   endfunction

   dds_pin_sync #(
      .WIDTH(3),
      .RST_VAL(dds_serial_load_pkg::SERIAL_PINS_RST)
   ) u_serial_sync (
      .clk(CLK),
      .arst_n(ARST_N),
      .ce(CE),
      .d({FRAME_SYNC_N, SERIAL_CLOCK, SERIAL_DATA_IN}),
      .q(ser_pins)
   );

   dds_pin_sync #(
      .WIDTH(3),
      .RST_VAL(dds_serial_load_pkg::SELECT_PINS_RST)
   ) u_select_sync (
      .clk(CLK),
      .arst_n(ARST_N),
      .ce(CE),
      .d({PHASE_SELECT_HI, PHASE_SELECT_LO, FREQ_REG_SELECT}),
      .q(sel_pins)
   );

   always_comb begin
      logic fall;
      logic in_v;
      logic app_v;
      logic [15:0] in_w;
      logic [15:0] app_w;
      logic [15:0] nd;
      logic [3:0] cmd;
      logic [2:0] pin_sel;
      logic [2:0] choose;
      logic [31:0] rd;
      fall = 1'b0;
      in_v = 1'b0;
      app_v = 1'b0;
      in_w = '0;
      app_w = '0;
      nd = '0;
      cmd = '0;
      pin_sel = '0;
      choose = '0;
      rd = '0;
      next_s = s;

      // serial shift register on synchronised falling edges
      fall = s.sclk_prev & ~ser_pins[1]; // R04
      next_s.sclk_prev = ser_pins[1];
      if (ser_pins[2]) begin
         if ((s.bit_cnt != 5'h00) &&
             (s.bit_cnt < dds_serial_load_pkg::BIT_COUNT_FULL)) begin
            next_s.drop_cnt = s.drop_cnt + 8'h01; // R27
         end
         next_s.bit_cnt = '0; // R27
      end else if (fall &&
                   (s.bit_cnt < dds_serial_load_pkg::BIT_COUNT_FULL)) begin
         next_s.shift = {s.shift[14:0], ser_pins[0]}; // R02
         next_s.bit_cnt = s.bit_cnt + 5'h01;
         if (s.bit_cnt == dds_serial_load_pkg::BIT_COUNT_LAST) begin
            in_v = 1'b1; // R01 R13
            in_w = {s.shift[14:0], ser_pins[0]};
         end
      end

      // injected word waits while a serial word completes
      if (!in_v && s.inject_v) begin
         in_v = 1'b1;
         in_w = s.inject_w;
         next_s.inject_v = 1'b0;
      end

      // optional two-stage alignment pipeline
      if (s.clock_align_enable) begin
         next_s.pipe_v = {s.pipe_v[0], in_v}; // R14
         next_s.pipe_w = {s.pipe_w[0], in_w};
         app_v = s.pipe_v[1];
         app_w = s.pipe_w[1];
      end else begin
         next_s.pipe_v = '0;
         app_v = in_v;
         app_w = in_w;
      end

      // data register to destination, one clock after the transfer
      next_s.dest_pending = 1'b0;
      if (s.dest_pending) begin
         if (s.dest_idx < dds_serial_load_pkg::DEST_FIRST_PHASE) begin
            next_s.freq_half[s.dest_idx[1:0]] = s.data; // R10 R13
         end else begin
            next_s.phase[s.dest_idx[1:0]] = s.data[11:0];
         end
      end

      // word decode
      cmd = app_w[dds_serial_load_pkg::CMD_MSB:dds_serial_load_pkg::CMD_LSB];
      nd = s.defer;
      if (app_w[dds_serial_load_pkg::ADDR_LSB]) begin
         nd[15:8] = app_w[7:0]; // R05
      end else begin
         nd[7:0] = app_w[7:0];
      end
      if (app_v) begin
         if (cmd[3:2] == dds_serial_load_pkg::CMD_SYNC_SOURCE) begin
            next_s.clock_align_enable =
               app_w[dds_serial_load_pkg::CTRL_A_BIT]; // R23
            next_s.select_source = app_w[dds_serial_load_pkg::CTRL_B_BIT];
         end else if (cmd[3:2] == dds_serial_load_pkg::CMD_SLEEP_RESET) begin
            next_s.sleep = app_w[dds_serial_load_pkg::CTRL_A_BIT]; // R24
            next_s.reset_bit = app_w[dds_serial_load_pkg::CTRL_B_BIT];
            if (app_w[dds_serial_load_pkg::CTRL_C_BIT]) begin
               next_s.clock_align_enable = 1'b0; // R12
               next_s.select_source = 1'b0;
            end
         end else if (cmd == dds_serial_load_pkg::CMD_DEFER) begin
            next_s.defer = nd; // R06
         end else if (cmd == dds_serial_load_pkg::CMD_DIRECT) begin
            next_s.defer = nd; // R07
            next_s.data = nd;
            next_s.dest_pending = 1'b1;
            next_s.dest_idx = app_w[dds_serial_load_pkg::ADDR_MSB:
                                    dds_serial_load_pkg::ADDR_LSB + 1];
         end else if (cmd == dds_serial_load_pkg::CMD_SELECT) begin
            next_s.fsel_bit = app_w[dds_serial_load_pkg::SEL_FREQ_BIT];
            next_s.psel_bit = app_w[dds_serial_load_pkg::SEL_PHASE_MSB:
                                    dds_serial_load_pkg::SEL_PHASE_LSB];
         end
      end

      // register selection source
      next_s.pin_pipe = {s.pin_pipe[0], sel_pins};
      pin_sel = s.clock_align_enable ? s.pin_pipe[1] : sel_pins; // R15
      choose = s.select_source ? {s.psel_bit, s.fsel_bit} : pin_sel; // R11
      next_s.sel_freq = choose[0]; // R16
      next_s.sel_phase = choose[2:1];
      next_s.sel_phase_d = s.sel_phase;

      // phase path; sleep freezes it, but the reset bit still zeroes the accumulator
      if (s.reset_bit) begin
         next_s.acc = '0; // R18 R20
      end else if (!s.sleep) begin
         next_s.acc = s.acc + freq_of(s.freq_half, s.sel_freq); // R21 R17
      end
      if (!s.sleep) begin
         next_s.phase_sum = s.acc[31:20] + s.phase[s.sel_phase_d]; // R26
         next_s.phase_out = s.phase_sum; // R25
      end

      // apb read capture during the setup cycle
      if (PSEL && !s.rd_ready) begin
         if (PADDR == dds_serial_load_pkg::OFS_STATUS) begin
            rd[dds_serial_load_pkg::ST_SELECT_SOURCE] = s.select_source;
            rd[dds_serial_load_pkg::ST_CLOCK_ALIGN] = s.clock_align_enable;
            rd[dds_serial_load_pkg::ST_SLEEP] = s.sleep;
            rd[dds_serial_load_pkg::ST_RESET_BIT] = s.reset_bit;
            rd[dds_serial_load_pkg::ST_SEL_FREQ] = s.sel_freq;
            rd[dds_serial_load_pkg::ST_SEL_PHASE_LSB +: 2] = s.sel_phase;
            rd[dds_serial_load_pkg::ST_INJECT_BUSY] = s.inject_v;
            rd[dds_serial_load_pkg::ST_DROP_LSB +: 8] = s.drop_cnt;
         end else if (PADDR == dds_serial_load_pkg::OFS_FREQ0) begin
            rd = freq_of(s.freq_half, 1'b0);
         end else if (PADDR == dds_serial_load_pkg::OFS_FREQ1) begin
            rd = freq_of(s.freq_half, 1'b1);
         end else if (PADDR == dds_serial_load_pkg::OFS_PHASE01) begin
            rd = {4'h0, s.phase[1], 4'h0, s.phase[0]};
         end else if (PADDR == dds_serial_load_pkg::OFS_PHASE23) begin
            rd = {4'h0, s.phase[3], 4'h0, s.phase[2]};
         end else if (PADDR == dds_serial_load_pkg::OFS_DEFER_DATA) begin
            rd = {s.data, s.defer};
         end else if (PADDR == dds_serial_load_pkg::OFS_WORD_INJECT) begin
            rd = {16'h0000, s.inject_w};
         end else if (PADDR == dds_serial_load_pkg::OFS_ACCUM) begin
            rd = s.acc;
         end
         next_s.rdata = rd;
         next_s.rd_ready = 1'b1;
      end
      // capture holds through wait states; cleared when the transfer ends
      if (!PSEL || (PENABLE && PREADY)) begin
         next_s.rd_ready = 1'b0;
      end

      // apb write: only the inject register is writable
      if (PSEL && PENABLE && PWRITE &&
          (PADDR == dds_serial_load_pkg::OFS_WORD_INJECT) && !s.inject_v) begin
         next_s.inject_v = 1'b1;
         next_s.inject_w = PWDATA[15:0];
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         s <= '0;
         s.reset_bit <= dds_serial_load_pkg::RESET_BIT_RST;
         s.sleep <= dds_serial_load_pkg::SLEEP_RST;
      end else if (CE) begin
         s <= next_s;
      end
   end

   // writes to the inject register stall while an injected word is pending
   assign PREADY = CE & (PWRITE ?
      !((PADDR == dds_serial_load_pkg::OFS_WORD_INJECT) && s.inject_v) :
      s.rd_ready);
   assign PSLVERR = PSEL & PENABLE & !addr_ok(PADDR);
   assign PRDATA = s.rdata;
   assign PHASE_ADDR = s.phase_out;
   assign POWER_DOWN = s.sleep;
endmodule // dds_serial_load_control

// File: hw/dds_serial_load_pkg.sv
package dds_serial_load_pkg;
   // serial word layout
   localparam int WORD_BITS = 16;
   localparam int CMD_MSB = 15;
   localparam int CMD_LSB = 12;
   localparam int ADDR_MSB = 11;
   localparam int ADDR_LSB = 8;
   localparam int CTRL_A_BIT = 13;
   localparam int CTRL_B_BIT = 12;
   localparam int CTRL_C_BIT = 11;
   localparam int SEL_FREQ_BIT = 11;
   localparam int SEL_PHASE_MSB = 10;
   localparam int SEL_PHASE_LSB = 9;
   localparam logic [4:0] BIT_COUNT_FULL = 5'h10;
   localparam logic [4:0] BIT_COUNT_LAST = 5'h0F;

   // commands in the top four bits
   localparam logic [3:0] CMD_DEFER = 4'h0;
   localparam logic [3:0] CMD_DIRECT = 4'h1;
   localparam logic [3:0] CMD_SELECT = 4'h2;
   localparam logic [1:0] CMD_SYNC_SOURCE = 2'h2;
   localparam logic [1:0] CMD_SLEEP_RESET = 2'h3;

   // destination index (address bits 3:1); address bit 0 picks the byte
   localparam logic [2:0] DEST_FIRST_PHASE = 3'h4;

   // phase path
   localparam int ACC_BITS = 32;
   localparam int PHASE_BITS = 12;
   localparam int SYNC_STAGES = 2;

   // values after reset
   localparam logic RESET_BIT_RST = 1'b1;
   localparam logic SLEEP_RST = 1'b0;
   localparam logic [2:0] SERIAL_PINS_RST = 3'h4;
   localparam logic [2:0] SELECT_PINS_RST = 3'h0;

   // register map, byte addresses
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_FREQ0 = 8'h04;
   localparam logic [7:0] OFS_FREQ1 = 8'h08;
   localparam logic [7:0] OFS_PHASE01 = 8'h0C;
   localparam logic [7:0] OFS_PHASE23 = 8'h10;
   localparam logic [7:0] OFS_DEFER_DATA = 8'h14;
   localparam logic [7:0] OFS_WORD_INJECT = 8'h18;
   localparam logic [7:0] OFS_ACCUM = 8'h1C;

   // status fields
   localparam int ST_SELECT_SOURCE = 0;
   localparam int ST_CLOCK_ALIGN = 1;
   localparam int ST_SLEEP = 2;
   localparam int ST_RESET_BIT = 3;
   localparam int ST_SEL_FREQ = 4;
   localparam int ST_SEL_PHASE_LSB = 5;
   localparam int ST_INJECT_BUSY = 7;
   localparam int ST_DROP_LSB = 8;
endpackage
